// ===== verif/tmds_receiver_pixel_output_test.sv
// Purpose: Self-checking bench for the pixel output stage.
// Assumes: pclk 5 ns; the link model runs its clock at 160 ns.
// Notes: Expected pixels are queued before each line and popped at each output clock rise with display_active high.
`timescale 1ns/1ps
module tmds_receiver_pixel_output_test import tpo_pkg::*; ();
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic link_clock_pair, lane_display_active, output_driver_powerdown_n, pixel_pair_select, stagger_select_n;
    logic [LANE_W-1:0] blue_lane_pair, green_lane_pair, red_lane_pair;
    logic [1:0] blue_lane_ctl, green_lane_ctl, red_lane_ctl;
    logic [PIX_W-1:0] even_pixel_bus, odd_pixel_bus;
    logic output_pixel_clock, display_active, hsync, vsync, aux_control_one, aux_control_two;
    logic link_active_flag, output_oe_n, opc_q;
    logic [2*PIX_W-1:0] exp_q[$];
    int err_count, cmp_count, cyc;
    tpo_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq,
        .link_clock_pair, .blue_lane_pair, .blue_lane_ctl, .green_lane_pair, .green_lane_ctl, .red_lane_pair,
        .red_lane_ctl, .lane_display_active, .output_driver_powerdown_n, .pixel_pair_select, .stagger_select_n,
        .even_pixel_bus, .odd_pixel_bus, .output_pixel_clock, .display_active, .hsync, .vsync, .aux_control_one,
        .aux_control_two, .link_active_flag, .output_oe_n);
    tpo_link_model link (.link_clock_pair, .blue_lane_pair, .blue_lane_ctl, .green_lane_pair, .green_lane_ctl,
        .red_lane_pair, .red_lane_ctl, .lane_display_active);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] want);
        cmp_count++;
        if (seen !== want) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic complete_run();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
        output logic [DATA_W-1:0] rd, output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50) begin
            check("pready", 48'h0, 48'h1);
            complete_run();
        end
    endtask
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] w,
        input string what);
        logic [DATA_W-1:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, rd, er);
        check(what, {er, rd & m}, {1'b0, w});
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] rd;
        logic er;
        apb(1'b1, a, d, rd, er);
    endtask
    task automatic run_line(input int n, input logic pair, input logic stagger_select_n_n);
        logic [PIX_W-1:0] px[$];
        logic [3:0] ctl;
        int k;
        @(posedge pclk);
        pixel_pair_select <= pair;
        stagger_select_n <= stagger_select_n_n;
        repeat (300) @(posedge pclk);
        ctl = 4'($urandom);
        for (int i = 0; i < n; i++) px.push_back(PIX_W'($urandom));
        for (int i = 0; i < n; i += (pair ? 2 : 1))
            exp_q.push_back({px[i], (pair && i + 1 < n) ? px[i+1] : 24'h0});
        link.send(ctl, px);
        k = 0;
        while (exp_q.size() != 0 && k < 400) begin
            @(posedge pclk);
            k++;
        end
        repeat (2) @(posedge link_clock_pair);
        check("queue left", 48'(exp_q.size()), 48'h0);
        check("controls", {aux_control_two, aux_control_one, vsync, hsync}, ctl);
        $display("Test line of %0d pixels done", n);
    endtask
    always @(posedge pclk) begin
        opc_q <= output_pixel_clock;
        if (output_pixel_clock === 1'b1 && opc_q === 1'b0 && display_active === 1'b1) begin
            if (exp_q.size() == 0) check("extra pixel", 48'h1, 48'h0);
            else check("pixel buses", {even_pixel_bus, odd_pixel_bus}, exp_q.pop_front());
        end
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        logic [DATA_W-1:0] rd;
        logic er;
        int k;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {pixel_pair_select, stagger_select_n} = '0;
        output_driver_powerdown_n = 1'b1;
        err_count = 0;
        cmp_count = 0;
        cyc = 0;
        void'($urandom(32'h76a7452c));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(REG_TIMEOUT, 32'hffff, 32'h1000, "timeout reset");
        rd_chk(REG_IRQ_ENABLE, 32'hf, 32'h0, "irq enable reset");
        apb(1'b0, 8'h1c, 32'h0, rd, er);
        check("unmapped", {er, rd}, {1'b1, 32'h0});
        wr(REG_TIMEOUT, 32'h28);
        wr(REG_IRQ_ENABLE, 32'h3);
        rd_chk(REG_TIMEOUT, 32'hffff, 32'h28, "timeout");
        $display("Test registers done");
        // Single mode with stagger low: stagger must not matter here
        run_line(7, 1'b0, 1'b0);
        check("link up", {link_active_flag, irq}, 2'b11);
        rd_chk(REG_IRQ_STATUS, 32'h3, 32'h1, "irq status up");
        wr(REG_IRQ_CLEAR, 32'hf);
        run_line(9, 1'b1, 1'b1);
        run_line(8, 1'b1, 1'b0);
        rd_chk(REG_STATUS, 32'hf, 32'h7, "status");
        rd_chk(REG_LINE_LEN, 32'hffff, 32'h8, "line length");
        k = 0;
        while (link_active_flag !== 1'b0 && k < 3000) begin
            @(posedge pclk);
            k++;
        end
        repeat (2) @(posedge pclk);
        check("link down", {link_active_flag, irq}, 2'b01);
        wr(REG_IRQ_ENABLE, 32'h0);
        repeat (3) @(posedge pclk);
        check("irq masked", irq, 1'b0);
        wr(REG_IRQ_CLEAR, 32'hf);
        rd_chk(REG_IRQ_STATUS, 32'hf, 32'h0, "irq cleared");
        $display("Test interrupt done");
        output_driver_powerdown_n <= link_active_flag;
        repeat (6) @(posedge pclk);
        check("float", output_oe_n, 1'b1);
        rd_chk(REG_STATUS, 32'h8, 32'h8, "status powerdown");
        output_driver_powerdown_n <= 1'b1;
        repeat (6) @(posedge pclk);
        check("drive", output_oe_n, 1'b0);
        $display("Test power-down done");
        complete_run();
    end
endmodule

// ===== verif/tpo_link_model.sv
// Purpose: Transmitter end of the link: free running pixel clock and decoded lanes.
// Assumes: Half period 80 ns; lanes change on the rising link edge.
// Notes: Pixel lanes toggle in blanking so any leak onto the buses shows.
`timescale 1ns/1ps
module tpo_link_model import tpo_pkg::*; (
    output logic link_clock_pair,
    output logic [LANE_W-1:0] blue_lane_pair,
    output logic [1:0] blue_lane_ctl,
    output logic [LANE_W-1:0] green_lane_pair,
    output logic [1:0] green_lane_ctl,
    output logic [LANE_W-1:0] red_lane_pair,
    output logic [1:0] red_lane_ctl,
    output logic lane_display_active
);
    initial begin
        link_clock_pair = 1'b0;
        {red_lane_pair, green_lane_pair, blue_lane_pair} = '0;
        {red_lane_ctl, green_lane_ctl, blue_lane_ctl} = '0;
        lane_display_active = 1'b0;
        #1.3;
        forever #80 link_clock_pair = ~link_clock_pair;
    end
    task automatic send(input logic [3:0] ctl, input logic [PIX_W-1:0] px[$]);
        for (int i = 0; i < px.size() + 7; i++) begin
            @(posedge link_clock_pair);
            lane_display_active <= i >= 6 && i < px.size() + 6;
            if (i >= 6 && i < px.size() + 6) begin
                {red_lane_pair, green_lane_pair, blue_lane_pair} <= px[i-6];
            end else begin
                {red_lane_pair, green_lane_pair, blue_lane_pair} <= ~{red_lane_pair, green_lane_pair, blue_lane_pair};
                {red_lane_ctl, green_lane_ctl, blue_lane_ctl} <= {1'b0, ctl[3], 1'b0, ctl[2], ctl[1:0]};
            end
        end
    endtask
endmodule

// ===== verif/tpo_props.sv
// Purpose: Port checks of the pixel output stage.
// Assumes: Link period near 32 pclk.
// Notes: Mode checks wait for the pins to settle, as pins act live.
`timescale 1ns/1ps
module tpo_props import tpo_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [PIX_W-1:0] even_pixel_bus,
    input wire logic [PIX_W-1:0] odd_pixel_bus,
    input wire logic output_pixel_clock,
    input wire logic display_active,
    input wire logic link_active_flag,
    input wire logic output_oe_n,
    input wire logic output_driver_powerdown_n,
    input wire logic pixel_pair_select,
    input wire logic stagger_select_n
);
    logic [7:0] cfg_cnt;
    logic [7:0] per_cnt;
    logic [7:0] want;
    logic [1:0] cfg_q;
    logic opc_q;
    logic act_q;
    logic fall;
    logic ok;
    assign fall = opc_q && !output_pixel_clock;
    assign ok = cfg_cnt == 8'hff;
    assign want = pixel_pair_select ? 8'h40 : 8'h20;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= 2'h0;
            cfg_cnt <= 8'h00;
        end else begin
            cfg_q <= {pixel_pair_select, stagger_select_n};
            if (cfg_q != {pixel_pair_select, stagger_select_n}) cfg_cnt <= 8'h00;
            else if (!ok) cfg_cnt <= cfg_cnt + 8'h01;
        end
    end
    // Period only judged inside a line, since pairing restarts at line start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opc_q <= 1'b0;
            act_q <= 1'b0;
            per_cnt <= 8'h00;
        end else begin
            opc_q <= output_pixel_clock;
            if (fall) act_q <= display_active;
            if (fall) per_cnt <= 8'h01;
            else if (per_cnt != 8'hff) per_cnt <= per_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence pd_low_s;
        (!output_driver_powerdown_n) [*5];
    endsequence
    sequence pd_high_s;
        output_driver_powerdown_n [*5];
    endsequence
    even_on_clock_a: assert property (ok && $changed(even_pixel_bus) |-> fall)
        else $error("even bus moved off the clock fall");
    odd_low_single_a: assert property (ok && !pixel_pair_select |-> odd_pixel_bus == '0)
        else $error("odd bus not low in single mode");
    stagger_apart_a: assert property (ok && pixel_pair_select && !stagger_select_n && $changed(odd_pixel_bus)
        |-> !fall)
        else $error("odd bus not staggered");
    buses_together_a: assert property (ok && pixel_pair_select && stagger_select_n && $changed(odd_pixel_bus)
        |-> fall)
        else $error("odd bus not with even bus");
    pd_float_a: assert property (pd_low_s |-> output_oe_n)
        else $error("drivers on during power-down");
    pd_drive_a: assert property (pd_high_s |-> !output_oe_n)
        else $error("drivers off without power-down");
    activity_follow_a: assert property ($changed(display_active) |-> ##[0:2] link_active_flag)
        else $error("activity flag missed a toggle");
    clock_period_a: assert property (ok && fall && display_active && act_q
        |-> per_cnt >= want - 8'h01 && per_cnt <= want + 8'h01)
        else $error("output clock period wrong");
endmodule
bind tpo_top tpo_props u_props (.pclk, .presetn, .even_pixel_bus, .odd_pixel_bus, .output_pixel_clock,
    .display_active, .link_active_flag, .output_oe_n, .output_driver_powerdown_n, .pixel_pair_select,
    .stagger_select_n);

// ===== verilog/tpo_act_if.sv
// Purpose: Carrier between the pixel path and the link activity monitor.
// Assumes: All signals on pclk.
// Notes: Pulses are one pclk wide.
`timescale 1ns/1ps
interface tpo_act_if import tpo_pkg::*; ();
    logic pix_tick;
    logic de_toggle;
    logic enable;
    logic [TIMEOUT_W-1:0] timeout;
    logic active;
    modport mon (input pix_tick, input de_toggle, input enable, input timeout, output active);
    modport ctl (output pix_tick, output de_toggle, output enable, output timeout, input active);
endinterface

// ===== verilog/tpo_activity.sv
// Purpose: Link activity monitor driven by display-active transitions.
// Assumes: Timeout counted in link pixels.
// Notes: Only display-active edges revive the flag, nothing else on the link does.
`timescale 1ns/1ps
module tpo_activity import tpo_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    tpo_act_if.mon act
);
    logic [TIMEOUT_W-1:0] idle_count;
    logic [TIMEOUT_W-1:0] next_idle;

    assign next_idle = idle_count + 16'h0001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_count <= '0;
            act.active <= 1'b0;
        end else if (!act.enable) begin
            idle_count <= '0;
            act.active <= 1'b0;
        end else if (act.de_toggle) begin
            idle_count <= '0;
            act.active <= 1'b1;
        end else if (act.pix_tick && act.active) begin
            if (next_idle >= act.timeout) begin
                idle_count <= '0;
                act.active <= 1'b0;
            end else begin
                idle_count <= next_idle;
            end
        end
    end
endmodule

// ===== verilog/tpo_pkg.sv
// Purpose: Shared constants, types and decode for the TMDS receiver pixel output block.
// Assumes: APB register window of 8 address bits, 32-bit data, pclk at 200 MHz.
// Notes: Behaviour
package tpo_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned LANE_W = 8;
    localparam int unsigned PIX_W = 24;
    localparam int unsigned BLUE_LSB = 0;
    localparam int unsigned GREEN_LSB = 8;
    localparam int unsigned RED_LSB = 16;
    localparam int unsigned TIMEOUT_W = 16;
    localparam int unsigned LEN_W = 16;
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_UP_BIT = 0;
    localparam int unsigned IRQ_DOWN_BIT = 1;
    localparam int unsigned IRQ_LINE_BIT = 2;
    localparam int unsigned IRQ_FRAME_BIT = 3;
    localparam int unsigned STAT_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_TIMEOUT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 8'h10;
    localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h14;
    localparam logic [ADDR_W-1:0] REG_LINE_LEN = 8'h18;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam logic [TIMEOUT_W-1:0] TIMEOUT_RESET = 16'h1000;
    localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 4'h0;

    typedef enum logic [2:0] {
        R_CTRL = 3'b000,
        R_STATUS = 3'b001,
        R_TIMEOUT = 3'b010,
        R_IRQ_STATUS = 3'b011,
        R_IRQ_CLEAR = 3'b100,
        R_IRQ_ENABLE = 3'b101,
        R_LINE_LEN = 3'b110,
        R_NONE = 3'b111
    } tpo_reg_t;

    typedef enum logic {
        PH_EVEN = 1'b0,
        PH_ODD = 1'b1
    } tpo_phase_t;

    typedef struct packed {
        logic clk;
        logic de;
        logic [1:0] red_ctl;
        logic [1:0] green_ctl;
        logic [1:0] blue_ctl;
        logic [LANE_W-1:0] red;
        logic [LANE_W-1:0] green;
        logic [LANE_W-1:0] blue;
    } tpo_link_t;

    function automatic tpo_reg_t tpo_decode(input logic [ADDR_W-1:0] addr);
        tpo_reg_t r;
        unique case (addr)
            REG_CTRL: r = R_CTRL;
            REG_STATUS: r = R_STATUS;
            REG_TIMEOUT: r = R_TIMEOUT;
            REG_IRQ_STATUS: r = R_IRQ_STATUS;
            REG_IRQ_CLEAR: r = R_IRQ_CLEAR;
            REG_IRQ_ENABLE: r = R_IRQ_ENABLE;
            REG_LINE_LEN: r = R_LINE_LEN;
            default: r = R_NONE;
        endcase
        return r;
    endfunction
endpackage

// ===== verilog/tpo_sync.sv
// Purpose: Two-stage synchroniser for inputs from outside the pclk domain.
// Assumes: Multi-bit words are only used once stable for several pclk cycles.
// Notes: First stage feeds only the second stage.
`timescale 1ns/1ps
module tpo_sync #(
    parameter int unsigned W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ===== verilog/tpo_top.sv
// Purpose: Pixel output stage of a TMDS receiver with APB control and interrupt.
// Assumes: Lanes arrive already decoded, on the recovered link clock, far slower than pclk.
// Notes: Outputs are retimed onto pclk; output_pixel_clock is made from detected link edges.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module tpo_top import tpo_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic link_clock_pair,
    input wire logic [LANE_W-1:0] blue_lane_pair,
    input wire logic [1:0] blue_lane_ctl,
    input wire logic [LANE_W-1:0] green_lane_pair,
    input wire logic [1:0] green_lane_ctl,
    input wire logic [LANE_W-1:0] red_lane_pair,
    input wire logic [1:0] red_lane_ctl,
    input wire logic lane_display_active,
    input wire logic output_driver_powerdown_n,
    input wire logic pixel_pair_select,
    input wire logic stagger_select_n,
    output logic [PIX_W-1:0] even_pixel_bus,
    output logic [PIX_W-1:0] odd_pixel_bus,
    output logic output_pixel_clock,
    output logic display_active,
    output logic hsync,
    output logic vsync,
    output logic aux_control_one,
    output logic aux_control_two,
    output logic link_active_flag,
    output logic output_oe_n
);
    tpo_link_t link_raw;
    tpo_link_t link_s;
    logic [2:0] pins_s;
    logic pd_n_s;
    logic pair_mode;
    logic stagger_select_n_n_s;
    logic clk_d;
    logic link_rise;
    logic link_fall;
    logic pix_tick;
    logic enable;
    logic [TIMEOUT_W-1:0] timeout;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [IRQ_W-1:0] irq_clear;
    logic [IRQ_W-1:0] irq_event;
    logic de_cap;
    logic vsync_cap;
    logic active_d;
    tpo_phase_t last_phase;
    tpo_phase_t cur_phase;
    logic de_rise;
    logic [PIX_W-1:0] pixel_now;
    logic [PIX_W-1:0] even_hold;
    logic even_de_hold;
    logic [PIX_W-1:0] odd_pend;
    logic odd_due;
    logic stagger_on;
    logic [LEN_W-1:0] len_count;
    logic [LEN_W-1:0] line_len;
    logic apb_access;
    logic apb_done;
    tpo_reg_t rsel;

    tpo_act_if act ();

    // The recovered link clock is sampled like any other pin; data words are read mid-pixel
    assign link_raw.clk = link_clock_pair;
    assign link_raw.de = lane_display_active;
    assign link_raw.red_ctl = red_lane_ctl;
    assign link_raw.green_ctl = green_lane_ctl;
    assign link_raw.blue_ctl = blue_lane_ctl;
    assign link_raw.red = red_lane_pair;
    assign link_raw.green = green_lane_pair;
    assign link_raw.blue = blue_lane_pair;

    tpo_sync #(
        .W($bits(tpo_link_t))
    ) u_link_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(link_raw),
        .q(link_s)
    );

    tpo_sync #(
        .W(3)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({~output_driver_powerdown_n, pixel_pair_select, stagger_select_n}),
        .q(pins_s)
    );

    // Crosses in its asserted sense, so the synchroniser reset keeps drivers on
    assign pd_n_s = ~pins_s[2];
    assign pair_mode = pins_s[1];
    assign stagger_select_n_n_s = pins_s[0];
    assign stagger_on = pair_mode & ~stagger_select_n_n_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_d <= 1'b0;
        end else begin
            clk_d <= link_s.clk;
        end
    end

    assign link_rise = link_s.clk & ~clk_d;
    assign link_fall = ~link_s.clk & clk_d;
    // Falling edge is mid-pixel, so the synchronised word has long settled there
    assign pix_tick = link_fall & enable;

    // Lanes: pixel bytes in active display, controls in blanking
    assign pixel_now = {link_s.red, link_s.green, link_s.blue};
    assign de_rise = link_s.de & ~de_cap;
    // First pixel of each active line is the even one
    assign cur_phase = de_rise ? PH_EVEN : ((last_phase == PH_EVEN) ? PH_ODD : PH_EVEN);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            de_cap <= 1'b0;
            last_phase <= PH_ODD;
            even_hold <= '0;
            even_de_hold <= 1'b0;
        end else if (pix_tick) begin
            de_cap <= link_s.de;
            last_phase <= cur_phase;
            if (cur_phase == PH_EVEN) begin
                even_hold <= link_s.de ? pixel_now : '0;
                even_de_hold <= link_s.de;
            end
        end
    end

    // Pixel buses; every change lands on the falling edge of output_pixel_clock, save the staggered odd bus, which moves on the next link rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            even_pixel_bus <= '0;
            display_active <= 1'b0;
        end else if (!enable) begin
            even_pixel_bus <= '0;
            display_active <= 1'b0;
        end else if (pix_tick) begin
            if (!pair_mode) begin
                even_pixel_bus <= link_s.de ? pixel_now : '0;
                display_active <= link_s.de;
            end else if (cur_phase == PH_ODD) begin
                even_pixel_bus <= even_hold;
                display_active <= even_de_hold;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            odd_pixel_bus <= '0;
            odd_pend <= '0;
            odd_due <= 1'b0;
        end else if (!enable || !pair_mode) begin
            odd_pixel_bus <= '0;
            odd_pend <= '0;
            odd_due <= 1'b0;
        end else if (pix_tick && cur_phase == PH_ODD) begin
            if (stagger_on) begin
                // Staggered: odd bus follows half a link pixel later to spread the switching current
                odd_pend <= link_s.de ? pixel_now : '0;
                odd_due <= 1'b1;
            end else begin
                odd_pixel_bus <= link_s.de ? pixel_now : '0;
                odd_due <= 1'b0;
            end
        end else if (odd_due && link_rise) begin
            odd_pixel_bus <= odd_pend;
            odd_due <= 1'b0;
        end
    end

    // Sync and control bits are taken only while the link is blanking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hsync <= 1'b0;
            vsync <= 1'b0;
            aux_control_one <= 1'b0;
            aux_control_two <= 1'b0;
        end else if (!enable) begin
            hsync <= 1'b0;
            vsync <= 1'b0;
            aux_control_one <= 1'b0;
            aux_control_two <= 1'b0;
        end else if (pix_tick && !link_s.de && (!pair_mode || cur_phase == PH_ODD)) begin
            hsync <= link_s.blue_ctl[0];
            vsync <= link_s.blue_ctl[1];
            aux_control_one <= link_s.green_ctl[0];
            aux_control_two <= link_s.red_ctl[0];
        end
    end

    // One link pixel per output period, or two in pair mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_pixel_clock <= 1'b0;
        end else if (!enable) begin
            output_pixel_clock <= 1'b0;
        end else if (!pair_mode) begin
            if (pix_tick) begin
                output_pixel_clock <= 1'b0;
            end else if (link_rise) begin
                output_pixel_clock <= 1'b1;
            end
        end else if (pix_tick) begin
            output_pixel_clock <= (cur_phase == PH_EVEN);
        end
    end

    // Driver enable; link_active_flag and aux_control_one are never floated
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_oe_n <= 1'b0;
        end else begin
            output_oe_n <= ~pd_n_s;
        end
    end

    assign act.pix_tick = pix_tick;
    assign act.de_toggle = pix_tick & (link_s.de != de_cap);
    assign act.enable = enable;
    assign act.timeout = timeout;
    assign link_active_flag = act.active;

    tpo_activity u_activity (
        .pclk(pclk),
        .presetn(presetn),
        .act(act)
    );

    // Length of the last active line in link pixels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_count <= '0;
            line_len <= '0;
        end else if (pix_tick) begin
            if (link_s.de) begin
                len_count <= de_rise ? 16'h0001 : len_count + 16'h0001;
            end else if (de_cap) begin
                line_len <= len_count;
            end
        end
    end

    // Interrupt events; a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_d <= 1'b0;
            vsync_cap <= 1'b0;
        end else begin
            active_d <= act.active;
            if (pix_tick && !link_s.de) begin
                vsync_cap <= link_s.blue_ctl[1];
            end
        end
    end

    always_comb begin
        irq_event = '0;
        irq_event[IRQ_UP_BIT] = act.active & ~active_d;
        irq_event[IRQ_DOWN_BIT] = ~act.active & active_d;
        irq_event[IRQ_LINE_BIT] = pix_tick & de_rise;
        irq_event[IRQ_FRAME_BIT] = pix_tick & ~link_s.de & link_s.blue_ctl[1] & ~vsync_cap;
    end

    assign irq_clear = (apb_done && pwrite && rsel == R_IRQ_CLEAR) ? pwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
            irq <= |(irq_status & irq_enable);
        end
    end

    // APB slave with one wait state
    assign apb_access = psel & penable;
    assign apb_done = apb_access & pready;
    assign rsel = tpo_decode(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= apb_access & ~pready;
            if (apb_access && !pready) begin
                pslverr <= (rsel == R_NONE);
                prdata <= '0;
                if (!pwrite) begin
                    unique case (rsel)
                        R_CTRL: prdata <= {31'h0, enable};
                        R_STATUS: prdata <= {28'h0, ~pd_n_s, stagger_on, pair_mode, act.active};
                        R_TIMEOUT: prdata <= {16'h0, timeout};
                        R_IRQ_STATUS: prdata <= {28'h0, irq_status};
                        R_IRQ_CLEAR: prdata <= '0;
                        R_IRQ_ENABLE: prdata <= {28'h0, irq_enable};
                        R_LINE_LEN: prdata <= {16'h0, line_len};
                        R_NONE: prdata <= '0;
                    endcase
                end
            end else if (!apb_access) begin
                pslverr <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= CTRL_ENABLE_RESET;
            timeout <= TIMEOUT_RESET;
            irq_enable <= IRQ_ENABLE_RESET;
        end else if (apb_done && pwrite) begin
            if (rsel == R_CTRL) begin
                enable <= pwdata[0];
            end
            if (rsel == R_TIMEOUT) begin
                timeout <= pwdata[TIMEOUT_W-1:0];
            end
            if (rsel == R_IRQ_ENABLE) begin
                irq_enable <= pwdata[IRQ_W-1:0];
            end
        end
    end
endmodule
